// *** design/mvret_pkg.sv ***
// constants and types for the move and return instruction executor
// How it works
// RULE1: store copies accumulator to 7-bit addressed register, one cycle.
// RULE2: load literal puts 8-bit immediate in accumulator, one cycle.
// RULE3: interrupt return pops stack, program counter takes popped top.
// RULE4: interrupt return sets global enable, bit 7 of interrupt control.
// RULE5: return-from-interrupt is one word and takes two instruction cycles.
// RULE6: literal return loads its 8-bit immediate into accumulator.
// RULE7: literal return pops stack, program counter takes return address.
// RULE8: return-with-literal is one word and takes two instruction cycles.
// RULE9: no-operation only advances the program counter, one cycle.
package mvret_pkg;
    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 7;
    localparam int PC_W      = 13;
    localparam int IRQ_EN_BIT = 7;
    localparam logic [7:0] ACC_RST  = 8'h00;
    localparam logic [7:0] INTC_RST = 8'h00;
    localparam logic [12:0] PC_RST  = 13'h0000;
    localparam int RET_CYCLES = 2;

    typedef enum logic [2:0] {
        MVRET_OP_NOP,
        MVRET_OP_STORE_ACC,
        MVRET_OP_LOAD_LIT,
        MVRET_OP_RET_IRQ,
        MVRET_OP_RET_LIT
    } mvret_op_t;

    typedef enum logic {
        MVRET_ST_FETCH,
        MVRET_ST_FLUSH
    } mvret_state_t;
endpackage : mvret_pkg

// *** design/mvret_exec.sv ***
// executor for store, load literal, no-op and the two return instructions
`timescale 1ns/1ns
module mvret_exec (
    // clock and reset
    input  wire logic                     sys_clk_in,
    input  wire logic                     sys_rst_in,
    // decoded instruction
    input  wire logic                     instr_valid_in,
    input  wire mvret_pkg::mvret_op_t     instr_op_in,
    input  wire logic [6:0]               file_addr_in,
    input  wire logic [7:0]               literal_in,
    // return stack
    input  wire logic [12:0]              stack_top_entry_in,
    output logic                          stack_pop_out,
    // file register array write port
    output logic                          file_wr_en_out,
    output logic [6:0]                    file_wr_addr_out,
    output logic [7:0]                    file_wr_data_out,
    // core state
    output logic [7:0]                    accumulator_out,
    output logic [12:0]                   program_counter_out,
    output logic [7:0]                    interrupt_control_reg_out,
    output logic                          global_irq_enable_out,
    output logic                          instr_ready_out,
    output logic                          instr_done_out
);
    mvret_pkg::mvret_state_t state_ff;
    logic [7:0]  acc_ff;
    logic [12:0] pc_ff;
    logic [7:0]  intc_ff;
    logic        wr_en_ff;
    logic [6:0]  wr_addr_ff;
    logic [7:0]  wr_data_ff;
    logic        pop_ff;
    logic        done_ff;
    logic        take;
    logic        is_ret;

    // returns hold off new instructions for the second cycle
    assign instr_ready_out = (state_ff == mvret_pkg::MVRET_ST_FETCH);
    assign take   = instr_valid_in && instr_ready_out;
    assign is_ret = (instr_op_in == mvret_pkg::MVRET_OP_RET_IRQ) ||
                    (instr_op_in == mvret_pkg::MVRET_OP_RET_LIT);

    // second cycle flushes the fetched word after a return
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_ff <= mvret_pkg::MVRET_ST_FETCH;
        end else begin
            unique case (state_ff)
                mvret_pkg::MVRET_ST_FETCH: begin
                    if (take && is_ret) begin
                        state_ff <= mvret_pkg::MVRET_ST_FLUSH; // RULE5 RULE8
                    end
                end
                // one dead cycle only, so a return costs exactly two
                mvret_pkg::MVRET_ST_FLUSH: begin
                    state_ff <= mvret_pkg::MVRET_ST_FETCH;
                end
            endcase
        end
    end

    // accumulator: literal loads only, status never touched
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            acc_ff <= mvret_pkg::ACC_RST;
        end else if (take && (instr_op_in == mvret_pkg::MVRET_OP_LOAD_LIT ||
                              instr_op_in == mvret_pkg::MVRET_OP_RET_LIT)) begin
            acc_ff <= literal_in; // RULE2 RULE6
        end
    end

    // program counter advances, or takes the popped return address
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pc_ff <= mvret_pkg::PC_RST;
        end else if (take && is_ret) begin
            pc_ff <= stack_top_entry_in; // RULE3 RULE7
        end else if (take) begin
            pc_ff <= pc_ff + 13'h0001; // RULE9
        end
    end

    // global enable set on return from interrupt
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            intc_ff <= mvret_pkg::INTC_RST;
        end else if (take && instr_op_in == mvret_pkg::MVRET_OP_RET_IRQ) begin
            intc_ff[mvret_pkg::IRQ_EN_BIT] <= 1'b1; // RULE4
        end
    end

    // file write port, registered so data comes from flip-flops
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wr_en_ff   <= 1'b0;
            wr_addr_ff <= 7'h00;
            wr_data_ff <= 8'h00;
        end else begin
            wr_en_ff <= take &&
                        (instr_op_in == mvret_pkg::MVRET_OP_STORE_ACC); // RULE1
            if (take && instr_op_in == mvret_pkg::MVRET_OP_STORE_ACC) begin
                wr_addr_ff <= file_addr_in; // RULE1
                wr_data_ff <= acc_ff;
            end
        end
    end

    // pop pulse and completion pulse
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pop_ff  <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            pop_ff  <= take && is_ret; // RULE3 RULE7
            done_ff <= (take && !is_ret) ||
                       (state_ff == mvret_pkg::MVRET_ST_FLUSH);
        end
    end

    assign stack_pop_out             = pop_ff;
    assign file_wr_en_out            = wr_en_ff;
    assign file_wr_addr_out          = wr_addr_ff;
    assign file_wr_data_out          = wr_data_ff;
    assign accumulator_out           = acc_ff;
    assign program_counter_out       = pc_ff;
    assign interrupt_control_reg_out = intc_ff;
    assign global_irq_enable_out     = intc_ff[mvret_pkg::IRQ_EN_BIT];
    assign instr_done_out            = done_ff;

    chk_store_write_data: assert property (@(posedge sys_clk_in) // RULE1
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_STORE_ACC |=>
        file_wr_en_out && file_wr_data_out == $past(acc_ff) &&
        file_wr_addr_out == $past(file_addr_in))
        else $error("store did not write accumulator");

    chk_load_lit_acc: assert property (@(posedge sys_clk_in) // RULE2
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_LOAD_LIT |=>
        accumulator_out == $past(literal_in) && instr_done_out)
        else $error("literal not loaded in one cycle");

    chk_ret_irq_pc: assert property (@(posedge sys_clk_in) // RULE3
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_RET_IRQ |=>
        stack_pop_out && program_counter_out == $past(stack_top_entry_in))
        else $error("return from interrupt did not pop");

    chk_ret_irq_enable: assert property (@(posedge sys_clk_in) // RULE4
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_RET_IRQ |=>
        global_irq_enable_out)
        else $error("global enable not set");

    chk_ret_irq_two: assert property (@(posedge sys_clk_in) // RULE5
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_RET_IRQ |=>
        !instr_ready_out && !instr_done_out ##1 instr_done_out)
        else $error("return from interrupt not two cycles");

    chk_ret_lit_acc: assert property (@(posedge sys_clk_in) // RULE6
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_RET_LIT |=>
        accumulator_out == $past(literal_in) && $stable(intc_ff))
        else $error("return literal not in accumulator");

    chk_ret_lit_pc: assert property (@(posedge sys_clk_in) // RULE7
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_RET_LIT |=>
        stack_pop_out && program_counter_out == $past(stack_top_entry_in))
        else $error("return literal did not load counter");

    chk_ret_lit_two: assert property (@(posedge sys_clk_in) // RULE8
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_RET_LIT |=>
        !instr_ready_out ##1 instr_ready_out && instr_done_out)
        else $error("return literal not two cycles");

    chk_nop_quiet: assert property (@(posedge sys_clk_in) // RULE9
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_NOP |=>
        program_counter_out == $past(pc_ff) + 13'h0001 &&
        $stable(acc_ff) && $stable(intc_ff) && !file_wr_en_out &&
        !stack_pop_out && instr_done_out)
        else $error("no-op changed state");

    chk_store_no_side: assert property (@(posedge sys_clk_in) // RULE1
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_STORE_ACC |=>
        $stable(acc_ff) && $stable(intc_ff) && !stack_pop_out &&
        instr_done_out && program_counter_out == $past(pc_ff) + 13'h0001)
        else $error("store changed state or took too long");

    chk_load_lit_quiet: assert property (@(posedge sys_clk_in) // RULE2
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_LOAD_LIT |=>
        !file_wr_en_out && !stack_pop_out && $stable(intc_ff) &&
        program_counter_out == $past(pc_ff) + 13'h0001)
        else $error("literal load touched other state");

    chk_ret_irq_acc: assert property (@(posedge sys_clk_in) // RULE3
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_RET_IRQ |=>
        $stable(acc_ff) && !file_wr_en_out)
        else $error("return from interrupt touched accumulator");

    // a word presented while flushing must leave no trace
    chk_flush_word_dropped: assert property (@(posedge sys_clk_in) // RULE5 RULE8
        disable iff (sys_rst_in)
        state_ff == mvret_pkg::MVRET_ST_FLUSH && instr_valid_in |=>
        $stable(acc_ff) && $stable(pc_ff) && !file_wr_en_out &&
        !stack_pop_out)
        else $error("instruction taken in flush cycle");

    chk_pop_one_pulse: assert property (@(posedge sys_clk_in) // RULE3 RULE7
        disable iff (sys_rst_in)
        stack_pop_out |=> !stack_pop_out)
        else $error("stack popped twice for one return");

    chk_ret_lit_busy: assert property (@(posedge sys_clk_in) // RULE8
        disable iff (sys_rst_in)
        take && instr_op_in == mvret_pkg::MVRET_OP_RET_LIT |=>
        !file_wr_en_out && !instr_done_out)
        else $error("return literal finished in one cycle");
endmodule : mvret_exec

// *** testbench/tb_move_and_return_instructions.sv ***
// self-checking bench for the move and return instruction executor
`timescale 1ns/1ns
module tb_move_and_return_instructions;
    logic                 sys_clk_in = 1'b0;
    logic                 sys_rst_in = 1'b1;
    logic                 valid      = 1'b0;
    mvret_pkg::mvret_op_t op         = mvret_pkg::MVRET_OP_NOP;
    logic [6:0]           addr       = 7'h00;
    logic [7:0]           lit        = 8'h00;
    logic [12:0]          top        = 13'h0000;
    logic                 pop, wr_en, irq_en, rdy, done;
    logic [6:0]           wr_addr;
    logic [7:0]           wr_data, acc, intc;
    logic [12:0]          pc;
    logic [7:0]           e_acc      = 8'h00;
    logic [12:0]          e_pc       = 13'h0000;
    logic                 e_irq_en   = 1'b0;
    logic [31:0]          seed       = 32'h19f73390;
    int                   n_errors   = 0;
    int                   tests_run  = 0;

    mvret_exec i_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .instr_valid_in(valid), .instr_op_in(op), .file_addr_in(addr),
        .literal_in(lit), .stack_top_entry_in(top), .stack_pop_out(pop),
        .file_wr_en_out(wr_en), .file_wr_addr_out(wr_addr),
        .file_wr_data_out(wr_data), .accumulator_out(acc),
        .program_counter_out(pc), .interrupt_control_reg_out(intc),
        .global_irq_enable_out(irq_en), .instr_ready_out(rdy),
        .instr_done_out(done));

    always #20 sys_clk_in = ~sys_clk_in;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // returns reload from the stack, everything else steps by one
    function automatic logic [12:0] exp_pc(input logic        r,
                                           input logic [12:0] t);
        return r ? t : e_pc + 13'h0001;
    endfunction : exp_pc

    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic run_op(input mvret_pkg::mvret_op_t o, input logic [6:0] a,
                          input logic [7:0] k, input logic [12:0] t);
        logic       r;
        logic       st;
        logic [7:0] old_acc;
        r = (o == mvret_pkg::MVRET_OP_RET_IRQ) ||
            (o == mvret_pkg::MVRET_OP_RET_LIT);
        st = (o == mvret_pkg::MVRET_OP_STORE_ACC);
        old_acc = e_acc;
        check(rdy, 1'b1);
        valid = 1'b1;
        op = o;
        addr = a;
        lit = k;
        top = t;
        @(negedge sys_clk_in);
        e_pc = exp_pc(r, t);
        if (o == mvret_pkg::MVRET_OP_LOAD_LIT ||
            o == mvret_pkg::MVRET_OP_RET_LIT)
            e_acc = k;
        if (o == mvret_pkg::MVRET_OP_RET_IRQ)
            e_irq_en = 1'b1;
        check(pc, e_pc);
        check(acc, e_acc);
        check(irq_en, e_irq_en);
        check(intc, {e_irq_en, 7'h00});
        check(pop, r);
        check(wr_en, st);
        if (st) begin
            check(wr_addr, a);
            check(wr_data, old_acc);
        end
        check(done, !r);
        check(rdy, !r);
        if (r) begin
            // the blocked cycle must swallow this load
            op = mvret_pkg::MVRET_OP_LOAD_LIT;
            lit = ~k;
            @(negedge sys_clk_in);
            check(done, 1'b1);
            check(acc, e_acc);
            check(pc, e_pc);
            check(pop, 1'b0);
        end
    endtask : run_op

    initial begin
        repeat (16) @(negedge sys_clk_in);
        sys_rst_in = 1'b0;
        check(acc, 8'h00);
        check(pc, 13'h0000);
        check(intc, 8'h00);
        for (int i = 0; i < 5; i++) begin
            run_op(mvret_pkg::mvret_op_t'(i), 7'h7f, 8'hff, 13'h1fff);
            run_op(mvret_pkg::mvret_op_t'(i), 7'h00, 8'h00, 13'h0000);
        end
        // second reset: enable must come back cleared, then set again
        valid = 1'b0;
        sys_rst_in = 1'b1;
        repeat (2) @(negedge sys_clk_in);
        sys_rst_in = 1'b0;
        e_acc = 8'h00;
        e_pc = 13'h0000;
        e_irq_en = 1'b0;
        check(irq_en, 1'b0);
        check(pc, 13'h0000);
        run_op(mvret_pkg::MVRET_OP_RET_IRQ, 7'h00, 8'h5a, 13'h0abc);
        repeat (300) begin
            seed = lfsr(seed);
            if (seed[2:0] > 3'h4) begin
                valid = 1'b0;
                @(negedge sys_clk_in);
                check(done, 1'b0);
                check(pc, e_pc);
            end else begin
                run_op(mvret_pkg::mvret_op_t'(seed[2:0]), seed[9:3],
                       seed[17:10], seed[30:18]);
            end
        end
        finish_test();
    end

    // about 400 cycles are needed; cut off well beyond that
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
endmodule : tb_move_and_return_instructions
